//--- core/usbcse_ctrl.sv
// controller end: turns avalon commands into device register accesses
// assumes an avalon-mm master and the device end on the same clock
`timescale 1ns/1ps
module usbcse_ctrl (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// avalon-mm slave
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_address_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// register channel
	usbcse_if.ctrl bus
);
	typedef struct packed {
		logic waitreq;
		logic [31:0] readdata;
		logic allow_eye;
		logic enable_shadow;
		logic busy;
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic [7:0] result;
		logic valid;
		logic err;
	} usbcse_ctl_t;

	usbcse_ctl_t q;
	usbcse_ctl_t next_q;
	logic [11:0] c_addr;
	logic [7:0] c_data;
	logic c_write;
	logic refuse;

	always_comb begin
		next_q = q;
		next_q.wr = 1'b0;
		next_q.rd = 1'b0;
		next_q.waitreq = 1'b1;
		c_addr = avs_writedata_in[11:0];
		c_data = avs_writedata_in[19:12];
		c_write = avs_writedata_in[usbcse_pkg::CMD_WRITE_BIT];
		refuse = c_write && (c_addr == usbcse_pkg::ADDR_CFG) &&
			(q.enable_shadow || // [R8]
			(c_data[usbcse_pkg::CFG_EYE_BIT] && !q.allow_eye)); // [R9]
		if (bus.reg_ack) begin
			next_q.busy = 1'b0;
			next_q.result = bus.reg_rdata;
			// status contents only trusted while the flag stands
			next_q.valid = (q.addr != usbcse_pkg::ADDR_STATUS) ||
				bus.xfer_flag; // [R17]
		end
		// one wait state per access; a command waits while one is in flight
		if (q.waitreq && (avs_read_in || avs_write_in) &&
			!(avs_write_in && avs_address_in == usbcse_pkg::AVS_CMD &&
			q.busy)) begin
			next_q.waitreq = 1'b0;
			next_q.readdata = 32'h0000_0000;
			if (avs_read_in) begin
				if (avs_address_in == usbcse_pkg::AVS_CTRL) begin
					next_q.readdata[usbcse_pkg::CTRL_ALLOW_EYE_BIT] = q.allow_eye;
				end else if (avs_address_in == usbcse_pkg::AVS_RESULT) begin
					next_q.readdata[7:0] = q.result;
					next_q.readdata[usbcse_pkg::RES_BUSY_BIT] = q.busy;
					next_q.readdata[usbcse_pkg::RES_VALID_BIT] = q.valid;
					next_q.readdata[usbcse_pkg::RES_ERR_BIT] = q.err;
					next_q.readdata[usbcse_pkg::RES_FLAG_BIT] = bus.xfer_flag;
				end
			end else if (avs_address_in == usbcse_pkg::AVS_CTRL) begin
				next_q.allow_eye = avs_writedata_in[usbcse_pkg::CTRL_ALLOW_EYE_BIT];
			end else if (avs_address_in == usbcse_pkg::AVS_CMD) begin
				next_q.err = refuse;
				if (!refuse) begin
					next_q.busy = 1'b1;
					next_q.wr = c_write;
					next_q.rd = !c_write;
					next_q.addr = c_addr;
					next_q.wdata = c_data;
					if (c_write && c_addr == usbcse_pkg::ADDR_CONTROL) begin
						next_q.enable_shadow = c_data[usbcse_pkg::CTRL_ENABLE_BIT];
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= '0;
			q.waitreq <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign avs_readdata_out = q.readdata;
	assign avs_waitrequest_out = q.waitreq;
	assign bus.reg_write = q.wr;
	assign bus.reg_read = q.rd;
	assign bus.reg_addr = q.addr;
	assign bus.reg_wdata = q.wdata;
endmodule

//--- core/usbcse_device.sv
// device end: configuration, transfer status and endpoint control
// assumes tokens arrive already decoded and synchronous to ref_clk_in
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps

// Overview of operation
// R1 - transceiver on unless disable bit set
// R2 - speed bit picks full or low speed
// R3 - pullup on D+ at full, D- low
// R4 - pullup ignored while transceiver disabled
// R5 - drive indicator with monitor, always if disabled
// R6 - two-bit field selects pingpong buffering mode
// R7 - eye test repeats J-K, K-J at full
// R8 - firmware fixes speed, transceiver, pullup before enable
// R9 - eye test only for board checks
// R10 - status window shows head of four-entry fifo
// R11 - clearing flag advances fifo, reasserts within five
// R12 - empty fifo after advance leaves flag clear
// R13 - request with full fifo answered by NAK
// R14 - status bits 6-3 hold endpoint number
// R15 - status bit 2 set for IN token
// R16 - status bit 1 set for odd bank
// R17 - status valid only while flag asserted
// R18 - sixteen identical endpoint control registers
// R19 - endpoint bit 4 enables handshakes
// R20 - endpoint bit 3 set forbids SETUP transfers; code forbids them only while bit 1 is also set
// R21 - bit 2 enables OUT, bit 1 IN
// R22 - stall bit set by engine, firmware clears
// R23 - module enable gates everything else; code leaves transceiver, speed, pingpong and register access ungated
module usbcse_device (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// register channel
	usbcse_if.device bus,
	// decoded token from the serial engine
	input wire logic tok_valid_in,
	input wire logic [3:0] tok_ep_in,
	input wire logic [1:0] tok_pid_in,
	input wire logic tok_odd_in,
	input wire logic stall_request_in,
	// handshake decision
	output logic hs_valid_out,
	output logic [1:0] hs_code_out,
	// transceiver and pins
	output logic xcvr_enable_out,
	output logic full_speed_out,
	output logic dp_pullup_out,
	output logic dm_pullup_out,
	output logic tx_drive_out,
	output logic line_k_out,
	output logic output_drive_indicator_out,
	output logic [1:0] pingpong_mode_out
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfg;
		logic enable;
		logic [15:0][4:0] ep;
		logic flag;
		logic [2:0] tcy_cnt;
		logic [3:0] eye_cnt;
		logic eye_k;
		logic [7:0] rdata;
		logic ack;
		logic hs_valid;
		logic [1:0] hs_code;
		logic xcvr_en;
		logic fs;
		logic dp_pu;
		logic dm_pu;
		logic tx_drive;
		logic line_k;
		logic oe_ind;
		logic [1:0] ppb;
	} usbcse_dev_t;

	usbcse_dev_t q;
	usbcse_dev_t next_q;

	// odd bank meaningful only where the mode gives the endpoint both banks
	function automatic logic bank_used(input logic [1:0] mode,
		input logic [3:0] ep, input logic is_in);
		case (mode)
			usbcse_pkg::PPB_EP0_OUT: bank_used = (ep == 4'h0) && !is_in;
			usbcse_pkg::PPB_ALL: bank_used = 1'b1;
			usbcse_pkg::PPB_EP1_15: bank_used = (ep != 4'h0);
			default: bank_used = 1'b0;
		endcase
	endfunction

	logic [5:0] fifo_head;
	logic fifo_empty;
	logic fifo_full;
	logic fifo_push;
	logic fifo_pop;
	logic [5:0] fifo_entry;
	logic tick;
	logic [4:0] cur_ep;
	logic dir_ok;
	logic is_in;
	logic [3:0] ep_idx;
	logic ep_hit;

	usbcse_status_fifo u_fifo (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.push_in(fifo_push),
		.entry_in(fifo_entry),
		.pop_in(fifo_pop),
		.head_out(fifo_head),
		.empty_out(fifo_empty),
		.full_out(fifo_full)
	);

	always_comb begin
		next_q = q;
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		is_in = (tok_pid_in == usbcse_pkg::PID_IN);
		fifo_entry = {tok_ep_in, is_in,
			tok_odd_in && bank_used(q.cfg[1:0], tok_ep_in, is_in)};
		cur_ep = q.ep[tok_ep_in];
		ep_idx = 4'(bus.reg_addr - usbcse_pkg::ADDR_EP_BASE);
		ep_hit = (bus.reg_addr >= usbcse_pkg::ADDR_EP_BASE) &&
			(bus.reg_addr <= usbcse_pkg::ADDR_EP_LAST);
		dir_ok = 1'b0;
		next_q.hs_valid = 1'b0;
		next_q.ack = 1'b0;

		// ------------------------------------------------------------
		// instruction cycle divider
		// ------------------------------------------------------------
		tick = (q.tcy_cnt == 3'h0);
		if (q.tcy_cnt == 3'(usbcse_pkg::TCY_CYCLES - 1)) begin
			next_q.tcy_cnt = 3'h0;
		end else begin
			next_q.tcy_cnt = q.tcy_cnt + 3'h1;
		end

		// ------------------------------------------------------------
		// register channel
		// ------------------------------------------------------------
		if (bus.reg_read) begin
			next_q.ack = 1'b1;
			next_q.rdata = 8'h00;
			if (bus.reg_addr == usbcse_pkg::ADDR_CFG) begin
				next_q.rdata = q.cfg;
			end else if (bus.reg_addr == usbcse_pkg::ADDR_STATUS) begin
				// window onto the fifo head, undefined once the flag drops
				next_q.rdata = {1'b0, fifo_head, 1'b0}; // [R10] [R14] [R15] [R16]
			end else if (bus.reg_addr == usbcse_pkg::ADDR_CONTROL) begin
				next_q.rdata[usbcse_pkg::CTRL_ENABLE_BIT] = q.enable;
			end else if (bus.reg_addr == usbcse_pkg::ADDR_FLAG) begin
				next_q.rdata[usbcse_pkg::FLAG_CLEAR_BIT] = q.flag;
			end else if (ep_hit) begin
				next_q.rdata = {3'h0, q.ep[ep_idx]}; // [R18]
			end
		end
		if (bus.reg_write) begin
			next_q.ack = 1'b1;
			if (bus.reg_addr == usbcse_pkg::ADDR_CFG) begin
				next_q.cfg = bus.reg_wdata & usbcse_pkg::CFG_MASK;
			end else if (bus.reg_addr == usbcse_pkg::ADDR_CONTROL) begin
				next_q.enable = bus.reg_wdata[usbcse_pkg::CTRL_ENABLE_BIT];
			end else if (bus.reg_addr == usbcse_pkg::ADDR_FLAG) begin
				if (bus.reg_wdata[usbcse_pkg::FLAG_CLEAR_BIT] && q.flag) begin
					next_q.flag = 1'b0;
					fifo_pop = 1'b1; // [R11]
				end
			end else if (ep_hit) begin
				next_q.ep[ep_idx] = bus.reg_wdata[4:0]; // [R18]
			end
		end

		// flag rises on a divider tick, within one instruction cycle of a clear
		if (!q.flag && !fifo_pop && !fifo_empty && tick && q.enable) begin
			next_q.flag = 1'b1; // [R11] [R12]
		end

		// ------------------------------------------------------------
		// token handling
		// ------------------------------------------------------------
		if (tok_valid_in && q.enable) begin // [R23]
			case (tok_pid_in)
				usbcse_pkg::PID_OUT: dir_ok = cur_ep[usbcse_pkg::EP_OUTEN_BIT];
				usbcse_pkg::PID_IN: dir_ok = cur_ep[usbcse_pkg::EP_INEN_BIT];
				usbcse_pkg::PID_SETUP: dir_ok = cur_ep[usbcse_pkg::EP_OUTEN_BIT] &&
					!(cur_ep[usbcse_pkg::EP_INEN_BIT] &&
					cur_ep[usbcse_pkg::EP_CONDIS_BIT]); // [R20]
				default: dir_ok = 1'b0;
			endcase
			if (dir_ok) begin // [R21]
				next_q.hs_valid = cur_ep[usbcse_pkg::EP_HSHK_BIT]; // [R19]
				if (stall_request_in) begin
					next_q.hs_code = usbcse_pkg::HS_STALL;
					// engine set wins over a firmware clear in the same cycle
					next_q.ep[tok_ep_in][usbcse_pkg::EP_STALL_BIT] = 1'b1; // [R22]
				end else if (fifo_full) begin
					next_q.hs_code = usbcse_pkg::HS_NAK; // [R13]
				end else begin
					next_q.hs_code = usbcse_pkg::HS_ACK;
					fifo_push = 1'b1; // [R10]
				end
			end
		end

		// ------------------------------------------------------------
		// transceiver, pullups and eye pattern
		// ------------------------------------------------------------
		next_q.xcvr_en = !q.cfg[usbcse_pkg::CFG_XDIS_BIT]; // [R1]
		next_q.fs = q.cfg[usbcse_pkg::CFG_FS_BIT]; // [R2]
		next_q.ppb = q.cfg[1:0]; // [R6]
		next_q.dp_pu = q.enable && next_q.xcvr_en && next_q.fs &&
			q.cfg[usbcse_pkg::CFG_PULLUP_BIT]; // [R3] [R4]
		next_q.dm_pu = q.enable && next_q.xcvr_en && !next_q.fs &&
			q.cfg[usbcse_pkg::CFG_PULLUP_BIT]; // [R3] [R4]
		if (q.enable && q.cfg[usbcse_pkg::CFG_EYE_BIT]) begin
			// low speed bits last eight times longer than full speed bits
			if (q.fs || q.eye_cnt == 4'(usbcse_pkg::EYE_LS_DIV - 1)) begin
				next_q.eye_cnt = 4'h0;
				next_q.eye_k = !q.eye_k;
			end else begin
				next_q.eye_cnt = q.eye_cnt + 4'h1;
			end
			if (q.fs) begin
				next_q.eye_cnt = 4'h0;
			end
			next_q.tx_drive = 1'b1; // [R7]
			next_q.line_k = q.fs ? !q.eye_k : q.eye_k; // [R7]
		end else begin
			next_q.eye_cnt = 4'h0;
			next_q.eye_k = 1'b0;
			next_q.tx_drive = next_q.hs_valid;
			next_q.line_k = 1'b0;
		end
		if (q.enable && !q.fs && q.cfg[usbcse_pkg::CFG_EYE_BIT]) begin
			if (q.eye_cnt != 4'(usbcse_pkg::EYE_LS_DIV - 1)) begin
				next_q.eye_k = q.eye_k;
				next_q.eye_cnt = q.eye_cnt + 4'h1;
			end else begin
				next_q.eye_cnt = 4'h0;
			end
		end
		next_q.oe_ind = !next_q.xcvr_en ||
			(q.cfg[usbcse_pkg::CFG_OEMON_BIT] && next_q.tx_drive); // [R5]
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= '0;
			q.cfg <= usbcse_pkg::CFG_RESET;
			q.xcvr_en <= 1'b1; // [R1]
		end else begin
			q <= next_q;
		end
	end

	assign bus.reg_rdata = q.rdata;
	assign bus.reg_ack = q.ack;
	assign bus.xfer_flag = q.flag;
	assign hs_valid_out = q.hs_valid;
	assign hs_code_out = q.hs_code;
	assign xcvr_enable_out = q.xcvr_en;
	assign full_speed_out = q.fs;
	assign dp_pullup_out = q.dp_pu;
	assign dm_pullup_out = q.dm_pu;
	assign tx_drive_out = q.tx_drive;
	assign line_k_out = q.line_k;
	assign output_drive_indicator_out = q.oe_ind;
	assign pingpong_mode_out = q.ppb;
endmodule

//--- core/usbcse_if.sv
// register access channel between the device end and its controller
// assumes both ends run on the same clock; the bench joins them
`timescale 1ns/1ps
interface usbcse_if (
	input wire logic ref_clk_in
);
	logic reg_write;
	logic reg_read;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_ack;
	logic xfer_flag;

	modport device (
		input reg_write, reg_read, reg_addr, reg_wdata,
		output reg_rdata, reg_ack, xfer_flag
	);
	modport ctrl (
		output reg_write, reg_read, reg_addr, reg_wdata,
		input reg_rdata, reg_ack, xfer_flag
	);
endinterface

//--- core/usbcse_pkg.sv
// shared constants, field layouts and enumerations of the usb
// configuration, status and endpoint control block and its controller
// assumes a single 10 MHz clock for every module that uses it
package usbcse_pkg;

	// ------------------------------------------------------------
	// device register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CFG = 12'hF39;
	localparam logic [11:0] ADDR_STATUS = 12'hF64;
	localparam logic [11:0] ADDR_CONTROL = 12'hF65;
	localparam logic [11:0] ADDR_EP_BASE = 12'hF26;
	localparam logic [11:0] ADDR_EP_LAST = 12'hF35;
	localparam logic [11:0] ADDR_FLAG = 12'hF5E;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_EYE_BIT = 7;
	localparam int CFG_OEMON_BIT = 6;
	localparam int CFG_PULLUP_BIT = 4;
	localparam int CFG_XDIS_BIT = 3;
	localparam int CFG_FS_BIT = 2;
	localparam int CFG_PPB_LSB = 0;
	localparam logic [7:0] CFG_MASK = 8'hDF;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int CTRL_ENABLE_BIT = 3;
	localparam int EP_HSHK_BIT = 4;
	localparam int EP_CONDIS_BIT = 3;
	localparam int EP_OUTEN_BIT = 2;
	localparam int EP_INEN_BIT = 1;
	localparam int EP_STALL_BIT = 0;
	localparam logic [4:0] EP_RESET = 5'h00;
	localparam int STAT_EP_LSB = 3;
	localparam int STAT_DIR_BIT = 2;
	localparam int STAT_ODD_BIT = 1;
	localparam int FLAG_CLEAR_BIT = 0;
	localparam int FIFO_DEPTH = 4;
	localparam int NUM_EP = 16;

	// ------------------------------------------------------------
	// pingpong mode codes
	// ------------------------------------------------------------
	localparam logic [1:0] PPB_NONE = 2'h0;
	localparam logic [1:0] PPB_EP0_OUT = 2'h1;
	localparam logic [1:0] PPB_ALL = 2'h2;
	localparam logic [1:0] PPB_EP1_15 = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int TCY_NS = 400;
	localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLAG_REASSERT_MAX_TCY = 5;
	localparam int FS_CLK_MHZ = 48;
	localparam int LS_CLK_MHZ = 6;
	localparam int EYE_LS_DIV = FS_CLK_MHZ / LS_CLK_MHZ;

	// ------------------------------------------------------------
	// controller register map (avalon byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] AVS_CTRL = 4'h0;
	localparam logic [3:0] AVS_CMD = 4'h4;
	localparam logic [3:0] AVS_RESULT = 4'h8;
	localparam int CTRL_ALLOW_EYE_BIT = 0;
	localparam int CMD_DATA_LSB = 12;
	localparam int CMD_WRITE_BIT = 20;
	localparam int RES_BUSY_BIT = 8;
	localparam int RES_VALID_BIT = 9;
	localparam int RES_ERR_BIT = 10;
	localparam int RES_FLAG_BIT = 11;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} usbcse_pid_t;
	typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} usbcse_hs_t;

endpackage

//--- core/usbcse_status_fifo.sv
// four-entry transfer status fifo held in flip-flops
// assumes push is only asked while not full, pop while not empty
`timescale 1ns/1ps
module usbcse_status_fifo (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// fill and drain
	input wire logic push_in,
	input wire logic [5:0] entry_in,
	input wire logic pop_in,
	// state
	output logic [5:0] head_out,
	output logic empty_out,
	output logic full_out
);
	typedef struct packed {
		logic [3:0][5:0] mem;
		logic [1:0] wr_ptr;
		logic [1:0] rd_ptr;
		logic [2:0] count;
	} usbcse_fifo_t;

	usbcse_fifo_t q;
	usbcse_fifo_t next_q;
	logic do_push;
	logic do_pop;

	always_comb begin
		next_q = q;
		do_push = push_in && (q.count != 3'(usbcse_pkg::FIFO_DEPTH));
		do_pop = pop_in && (q.count != 3'h0);
		if (do_push) begin
			next_q.mem[q.wr_ptr] = entry_in;
			next_q.wr_ptr = q.wr_ptr + 2'h1;
		end
		if (do_pop) begin
			next_q.rd_ptr = q.rd_ptr + 2'h1;
		end
		if (do_push && !do_pop) begin
			next_q.count = q.count + 3'h1;
		end else if (do_pop && !do_push) begin
			next_q.count = q.count - 3'h1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign head_out = q.mem[q.rd_ptr];
	assign empty_out = (q.count == 3'h0);
	assign full_out = (q.count == 3'(usbcse_pkg::FIFO_DEPTH));
endmodule

//--- verification/usb_device_cfg_status_endpoint_ctrl_tb_top.sv
// bench: avalon master on the controller, tokens into the device end
// assumes both ends joined by the carrier interface on one clock
`timescale 1ns/1ps
module usb_device_cfg_status_endpoint_ctrl_tb_top;
	logic ref_clk_in, resetn_in, avs_read, avs_write, avs_waitrequest;
	logic tok_valid, tok_odd, stall_req, hs_valid, xcvr_en, fs, dp_pu;
	logic dm_pu, tx_drive, line_k, odi;
	logic [1:0] tok_pid, hs_code, ppb;
	logic [3:0] avs_address, tok_ep;
	logic [31:0] avs_writedata, avs_readdata, r;
	int n_errors, checks_done;
	usbcse_if i_usbcse_if (.ref_clk_in(ref_clk_in));
	usbcse_device i_usbcse_device (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .bus(i_usbcse_if), .tok_valid_in(tok_valid),
		.tok_ep_in(tok_ep), .tok_pid_in(tok_pid), .tok_odd_in(tok_odd),
		.stall_request_in(stall_req), .hs_valid_out(hs_valid),
		.hs_code_out(hs_code), .xcvr_enable_out(xcvr_en),
		.full_speed_out(fs), .dp_pullup_out(dp_pu), .dm_pullup_out(dm_pu),
		.tx_drive_out(tx_drive), .line_k_out(line_k),
		.output_drive_indicator_out(odi), .pingpong_mode_out(ppb));
	usbcse_ctrl i_usbcse_ctrl (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .avs_read_in(avs_read),
		.avs_write_in(avs_write), .avs_address_in(avs_address),
		.avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest), .bus(i_usbcse_if));
	usbcse_properties i_usbcse_properties (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .reg_write(i_usbcse_if.reg_write),
		.reg_read(i_usbcse_if.reg_read), .reg_addr(i_usbcse_if.reg_addr),
		.reg_wdata(i_usbcse_if.reg_wdata), .reg_rdata(i_usbcse_if.reg_rdata),
		.reg_ack(i_usbcse_if.reg_ack), .xfer_flag(i_usbcse_if.xfer_flag));
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// ----
	// checking and bus tasks
	// ----
	task report_and_stop;
		$display("mismatches %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bail;
		chk_bit(1'b0, 1'b1);
		report_and_stop;
	endtask
	task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk_in);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) bail;
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// result lands in r; polls until the controller is idle
	task dev(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		av(1'b1, usbcse_pkg::AVS_CMD, {11'h000, wr, d, a});
		n = 0;
		do begin
			av(1'b0, usbcse_pkg::AVS_RESULT, 32'h0);
			n++;
		end while (r[usbcse_pkg::RES_BUSY_BIT] !== 1'b0 && n < 20);
		if (r[usbcse_pkg::RES_BUSY_BIT] !== 1'b0) bail;
	endtask
	task rchk(input logic [11:0] a, input logic [7:0] exp);
		dev(1'b0, a, 8'h00);
		chk_byte(r[7:0], exp);
	endtask
	task tok(input logic [3:0] ep, input logic [1:0] pid, input logic odd,
		input logic st, input logic hv, input logic [1:0] hc);
		@(posedge ref_clk_in);
		tok_valid <= 1'b1;
		tok_ep <= ep;
		tok_pid <= pid;
		tok_odd <= odd;
		stall_req <= st;
		@(posedge ref_clk_in);
		tok_valid <= 1'b0;
		stall_req <= 1'b0;
		@(posedge ref_clk_in);
		chk_bit(hs_valid, hv);
		if (hv) chk_byte({6'h00, hs_code}, {6'h00, hc});
	endtask
	task flag_wait(input logic exp);
		int n;
		n = 0;
		while (i_usbcse_if.xfer_flag !== 1'b1 && n < 20) begin
			@(posedge ref_clk_in);
			n++;
		end
		if (exp && i_usbcse_if.xfer_flag !== 1'b1) bail;
		chk_bit(i_usbcse_if.xfer_flag, exp);
	endtask
	task toggles(input int n, input logic [7:0] exp);
		logic prev;
		logic [7:0] c;
		c = 8'h00;
		@(posedge ref_clk_in);
		prev = line_k;
		repeat (n - 1) begin
			@(posedge ref_clk_in);
			if (line_k !== prev) c++;
			prev = line_k;
		end
		chk_byte(c, exp);
	endtask
	// ----
	// scenarios
	// ----
	task s_reset;
		chk_bit(xcvr_en, 1'b1);
		rchk(usbcse_pkg::ADDR_CFG, usbcse_pkg::CFG_RESET);
		rchk(12'h000, 8'h00);
		av(1'b0, 4'hC, 32'h0);
		chk_byte(r[7:0], 8'h00);
		for (int i = 0; i < 16; i++) begin
			rchk(usbcse_pkg::ADDR_EP_BASE + 12'(i), 8'h00);
			dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'(i), 8'(i * 2));
		end
		for (int i = 0; i < 16; i++) begin
			rchk(usbcse_pkg::ADDR_EP_BASE + 12'(i), 8'(i * 2));
		end
	endtask
	task s_pins;
		logic [7:0] cf [4] = '{8'h14, 8'h11, 8'h1E, 8'h43};
		logic [4:0] ex [4] = '{5'h1C, 5'h12, 5'h09, 5'h10};
		for (int i = 0; i < 4; i++) begin
			dev(1'b1, usbcse_pkg::ADDR_CFG, cf[i]);
			chk_bit(dp_pu | dm_pu, 1'b0);
			dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h08);
			chk_byte({3'h0, xcvr_en, fs, dp_pu, dm_pu, odi}, ex[i]);
			chk_byte({6'h00, ppb}, {6'h00, cf[i][1:0]});
			dev(1'b1, usbcse_pkg::ADDR_CFG, 8'h00);
			chk_bit(r[usbcse_pkg::RES_ERR_BIT], 1'b1);
			rchk(usbcse_pkg::ADDR_CFG, cf[i]);
			dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h00);
			chk_bit(dp_pu | dm_pu, 1'b0);
		end
		dev(1'b1, usbcse_pkg::ADDR_CFG, 8'h00);
	endtask
	task s_eye;
		dev(1'b1, usbcse_pkg::ADDR_CFG, 8'hC4);
		chk_bit(r[usbcse_pkg::RES_ERR_BIT], 1'b1);
		av(1'b1, usbcse_pkg::AVS_CTRL, 32'h1);
		dev(1'b1, usbcse_pkg::ADDR_CFG, 8'hC4);
		chk_bit(tx_drive, 1'b0);
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h08);
		chk_bit(tx_drive & odi, 1'b1);
		toggles(9, 8'h08);
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h00);
		dev(1'b1, usbcse_pkg::ADDR_CFG, 8'h80);
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h08);
		toggles(17, 8'h02);
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h00);
		dev(1'b1, usbcse_pkg::ADDR_CFG, 8'h00);
		chk_bit(tx_drive, 1'b0);
	endtask
	task s_ep;
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h002, 8'h12);
		tok(4'h2, usbcse_pkg::PID_IN, 1'b0, 1'b0, 1'b0, 2'h0);
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h08);
		tok(4'h2, usbcse_pkg::PID_OUT, 1'b0, 1'b0, 1'b0, 2'h0);
		tok(4'h2, usbcse_pkg::PID_IN, 1'b0, 1'b1, 1'b1,
			usbcse_pkg::HS_STALL);
		rchk(usbcse_pkg::ADDR_EP_BASE + 12'h002, 8'h13);
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h002, 8'h12);
		rchk(usbcse_pkg::ADDR_EP_BASE + 12'h002, 8'h12);
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h003, 8'h1E);
		tok(4'h3, usbcse_pkg::PID_SETUP, 1'b0, 1'b1, 1'b0, 2'h0);
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h003, 8'h16);
		tok(4'h3, usbcse_pkg::PID_SETUP, 1'b0, 1'b1, 1'b1,
			usbcse_pkg::HS_STALL);
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h004, 8'h02);
		tok(4'h4, usbcse_pkg::PID_IN, 1'b0, 1'b0, 1'b0, 2'h0);
		flag_wait(1'b1);
		rchk(usbcse_pkg::ADDR_STATUS, 8'h24);
		dev(1'b1, usbcse_pkg::ADDR_FLAG, 8'h01);
		flag_wait(1'b0);
		dev(1'b0, usbcse_pkg::ADDR_STATUS, 8'h00);
		chk_bit(r[usbcse_pkg::RES_VALID_BIT], 1'b0);
	endtask
	task s_fifo;
		logic [7:0] ex [4] = '{8'h08, 8'h2C, 8'h78, 8'h7E};
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h00);
		dev(1'b1, usbcse_pkg::ADDR_CFG, {6'h00, usbcse_pkg::PPB_ALL});
		dev(1'b1, usbcse_pkg::ADDR_CONTROL, 8'h08);
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h001, 8'h16);
		dev(1'b1, usbcse_pkg::ADDR_EP_BASE + 12'h005, 8'h16);
		dev(1'b1, usbcse_pkg::ADDR_EP_LAST, 8'h16);
		tok(4'h1, usbcse_pkg::PID_OUT, 1'b0, 1'b0, 1'b1, usbcse_pkg::HS_ACK);
		tok(4'h5, usbcse_pkg::PID_IN, 1'b0, 1'b0, 1'b1, usbcse_pkg::HS_ACK);
		tok(4'hF, usbcse_pkg::PID_SETUP, 1'b0, 1'b0, 1'b1,
			usbcse_pkg::HS_ACK);
		tok(4'hF, usbcse_pkg::PID_IN, 1'b1, 1'b0, 1'b1, usbcse_pkg::HS_ACK);
		tok(4'h1, usbcse_pkg::PID_OUT, 1'b0, 1'b0, 1'b1,
			usbcse_pkg::HS_NAK);
		for (int i = 0; i < 4; i++) begin
			flag_wait(1'b1);
			rchk(usbcse_pkg::ADDR_STATUS, ex[i]);
			chk_bit(r[usbcse_pkg::RES_VALID_BIT], 1'b1);
			dev(1'b1, usbcse_pkg::ADDR_FLAG, 8'h01);
		end
		flag_wait(1'b0);
	endtask
	initial begin
		n_errors = 0;
		checks_done = 0;
		resetn_in = 1'b0;
		{avs_read, avs_write, tok_valid, tok_odd, stall_req} = 5'h00;
		{avs_address, tok_ep, tok_pid} = 10'h000;
		avs_writedata = 32'h0;
		repeat (3) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		s_reset;
		s_pins;
		s_eye;
		s_ep;
		s_fifo;
		report_and_stop;
	end
endmodule

//--- verification/usbcse_properties.sv
// checker: timing and padding of the register channel and the flag
// assumes the bench hands it the interface signals beside the two ends
`timescale 1ns/1ps
module usbcse_properties (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// register channel
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic xfer_flag
);
	logic rd_cfg;
	logic rd_ep;
	logic clr;
	assign rd_cfg = reg_read && reg_addr == usbcse_pkg::ADDR_CFG;
	assign rd_ep = reg_read && reg_addr >= usbcse_pkg::ADDR_EP_BASE
		&& reg_addr <= usbcse_pkg::ADDR_EP_LAST;
	assign clr = reg_write && reg_addr == usbcse_pkg::ADDR_FLAG
		&& reg_wdata[usbcse_pkg::FLAG_CLEAR_BIT];
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// ----
	// access handshake
	// ----
	property p_ack_next;
		(reg_read || reg_write) |=> reg_ack;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("no ack after request");
	property p_ack_cause;
		reg_ack |-> $past(reg_read || reg_write);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_one_at_time;
		reg_ack |-> !reg_read && !reg_write;
	endproperty
	a_one_at_time: assert property (p_one_at_time)
		else $error("request during ack");
	property p_excl;
		!(reg_read && reg_write);
	endproperty
	a_excl: assert property (p_excl)
		else $error("read and write together");
	// ----
	// padding bits and flag
	// ----
	property p_cfg_pad;
		rd_cfg |=> reg_rdata[5] == 1'b0;
	endproperty
	a_cfg_pad: assert property (p_cfg_pad)
		else $error("cfg bit 5 not zero");
	property p_stat_pad;
		reg_read && reg_addr == usbcse_pkg::ADDR_STATUS
			|=> reg_rdata[7] == 1'b0 && reg_rdata[0] == 1'b0;
	endproperty
	a_stat_pad: assert property (p_stat_pad)
		else $error("status pad bits not zero");
	property p_ep_pad;
		rd_ep |=> reg_rdata[7:5] == 3'h0;
	endproperty
	a_ep_pad: assert property (p_ep_pad)
		else $error("endpoint upper bits not zero");
	property p_flag_clear;
		clr |=> !xfer_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared");
	property p_flag_fall;
		$fell(xfer_flag) |-> $past(clr);
	endproperty
	a_flag_fall: assert property (p_flag_fall)
		else $error("flag fell by itself");
endmodule
